// *** bench/charger_event_flag_mask_bank_test.sv ***
// self-checking bench for the charger event flag and mask bank
// assumes the host model owns the register port; the bench drives the detectors
`timescale 1ns/10ps
module charger_event_flag_mask_bank_test;
  import event_bank_pkg::*;
  localparam int CYCLE_LIMIT = 5000;
  logic        mclk;
  logic        rst_b;
  logic [24:0] ev;
  logic [2:0]  dir_sel;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_wdata;
  logic [7:0]  reg_rdata_ff;
  logic        reg_rvalid_ff;
  logic        irq_ff;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          seed;
  int          a;
  int          k;
  int          model[8];
  int          bitpos[25] = '{6,5,4,3,2,1,0,7,5,4,3,2,1,0,7,6,5,4,0,6,5,4,2,1,0};

  // ==========================================================
  // design and host
  charger_event_flag_mask_bank i_dut
  (
    .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
    .irq_ff(irq_ff), .taper_entry_evt(ev[0]), .charge_done_evt(ev[1]),
    .input_limit_evt(ev[2]), .power_path_mgmt_evt(ev[3]), .input_voltage_mgmt_evt(ev[4]),
    .thermal_regulation_evt(ev[5]), .input_good_change_evt(ev[6]),
    .input_overvoltage_evt(ev[7]), .battery_overcurrent_evt(ev[8]),
    .battery_undervoltage_evt(ev[9]), .thermistor_cold_evt(ev[10]),
    .thermistor_cool_evt(ev[11]), .thermistor_warm_evt(ev[12]),
    .thermistor_hot_evt(ev[13]), .adc_done_evt(ev[14]), .comparator_one_evt(ev[15]),
    .comparator_two_evt(ev[16]), .comparator_three_evt(ev[17]),
    .comparator_one_direction_sel(dir_sel[0]), .comparator_two_direction_sel(dir_sel[1]),
    .comparator_three_direction_sel(dir_sel[2]), .thermistor_open_evt(ev[18]),
    .watchdog_expiry_evt(ev[19]), .charge_timer_expiry_evt(ev[20]),
    .regulator_overcurrent_evt(ev[21]), .button_wake_one_evt(ev[22]),
    .button_wake_two_evt(ev[23]), .button_reset_warning_evt(ev[24])
  );

  host_model i_host
  (
    .mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff)
  );

  // ==========================================================
  // clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // a stuck handshake would otherwise run forever
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == CYCLE_LIMIT)
    begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // checking helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // only charger flags are maskable; the other three registers always interrupt
  function automatic logic exp_irq();
    return ((model[3] & ~model[7]) | model[4] | model[5] | model[6]) != 0;
  endfunction

  task automatic check_irq(input string what);
    check(what, {7'h00, irq_ff}, {7'h00, exp_irq()});
  endtask

  // a read of a flag register empties it in the model too
  task automatic read_check(input logic [7:0] addr, input string what);
    logic [7:0] data;
    logic       valid;
    i_host.read_reg(addr, data, valid);
    check("read valid", {7'h00, valid}, 8'h01);
    check(what, data, (addr inside {[8'h03:8'h07]}) ? 8'(model[addr[2:0]]) : 8'h00);
    if (addr inside {[8'h03:8'h06]})
      model[addr[2:0]] = 0;
    check_irq("irq after read");
  endtask

  // detectors need several cycles to pass the synchroniser and edge finder
  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    seed = 32'h845886fc;
    rst_b = 1'b0;
    ev = '0;
    dir_sel = 3'b111;
    foreach (model[j]) model[j] = 0;
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
    for (int r = 3; r <= 7; r++) read_check(8'(r), "reset value");
    read_check(8'h20, "unmapped read");
    i_host.write_reg(8'h03, 8'hff);
    read_check(8'h03, "flag write ignored");
    $display("test reset done");
    // every detector: rise, read twice across the fall; both-edge and inverted bits differ
    for (int i = 0; i < 25; i++)
    begin
      a = i < 7 ? 3 : i < 14 ? 4 : i < 19 ? 5 : 6;
      @(posedge mclk);
      ev[i] <= 1'b1;
      settle();
      if (i != 9) model[a] |= 1 << bitpos[i];
      check_irq("irq on event");
      if (a == 3)
        read_check(8'(a), "flag on rise");
      else if (a == 4)
        read_check(8'(a), "flag on rise");
      else if (a == 5)
        read_check(8'(a), "flag on rise");
      else
        read_check(8'(a), "flag on rise");
      @(posedge mclk);
      ev[i] <= 1'b0;
      settle();
      if (i == 6 || i == 9) model[a] |= 1 << bitpos[i];
      read_check(8'(a), "flag on fall");
    end
    $display("test detectors done");
    // below-threshold direction: the condition is met when the measurement is low
    @(posedge mclk);
    dir_sel <= 3'b000;
    settle();
    model[5] |= 8'h70;
    read_check(8'h05, "comparator below");
    @(posedge mclk);
    ev[17:15] <= 3'b111;
    settle();
    read_check(8'h05, "comparator above ignored");
    @(posedge mclk);
    ev[17:15] <= 3'b000;
    settle();
    model[5] |= 8'h70;
    read_check(8'h05, "comparator back below");
    $display("test comparator direction done");
    // random masks: a masked charger event still latches but stays silent
    for (int n = 0; n < 6; n++)
    begin
      model[7] = $random(seed) & 8'hff;
      i_host.write_reg(8'h07, 8'(model[7]));
      read_check(8'h07, "mask readback");
      k = $unsigned($random(seed)) % 6;
      @(posedge mclk);
      ev[k] <= 1'b1;
      settle();
      model[3] |= 1 << bitpos[k];
      check_irq("irq under mask");
      read_check(8'h03, "masked flag latched");
      @(posedge mclk);
      ev[k] <= 1'b0;
      settle();
    end
    $display("test masks done");
    report_and_stop();
  end
endmodule

// *** bench/host_model.sv ***
// host side of the byte register port: one-cycle strobes, one request at a time
// assumes the bank answers a read one cycle after the strobe edge
`timescale 1ns/10ps
module host_model
(
  input  wire logic       mclk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_ff,
  input  wire logic       reg_rvalid_ff
);
  // ==========================================================
  // idle bus
  // strobes low from time zero; data is inverted on release so stale values never match
  initial
  begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 8'h00;
  end

  // one write strobe; a mask byte written here decides which charger flags interrupt
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    @(posedge mclk);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_wdata <= ~data;
  endtask

  // one read strobe; the answer is taken just after the edge that samples the strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data,
                          output logic valid);
    @(posedge mclk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data  = reg_rdata_ff;
    valid = reg_rvalid_ff;
  endtask
endmodule

// *** design/charger_event_flag_mask_bank.sv ***
// event flag and charger mask registers with the host interrupt request
// assumes a serial bus slave in front drives the byte-wide register port
`timescale 1ns/10ps
module charger_event_flag_mask_bank
(
  input  wire logic                            mclk,
  input  wire logic                            rst_b,
  input  wire logic [event_bank_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  input  wire logic [event_bank_pkg::DATA_W-1:0] reg_wdata,
  output logic      [event_bank_pkg::DATA_W-1:0] reg_rdata_ff,
  output logic                                 reg_rvalid_ff,
  output logic                                 irq_ff,
  input  wire logic                            taper_entry_evt,
  input  wire logic                            charge_done_evt,
  input  wire logic                            input_limit_evt,
  input  wire logic                            power_path_mgmt_evt,
  input  wire logic                            input_voltage_mgmt_evt,
  input  wire logic                            thermal_regulation_evt,
  input  wire logic                            input_good_change_evt,
  input  wire logic                            input_overvoltage_evt,
  input  wire logic                            battery_overcurrent_evt,
  input  wire logic                            battery_undervoltage_evt,
  input  wire logic                            thermistor_cold_evt,
  input  wire logic                            thermistor_cool_evt,
  input  wire logic                            thermistor_warm_evt,
  input  wire logic                            thermistor_hot_evt,
  input  wire logic                            adc_done_evt,
  input  wire logic                            comparator_one_evt,
  input  wire logic                            comparator_two_evt,
  input  wire logic                            comparator_three_evt,
  input  wire logic                            comparator_one_direction_sel,
  input  wire logic                            comparator_two_direction_sel,
  input  wire logic                            comparator_three_direction_sel,
  input  wire logic                            thermistor_open_evt,
  input  wire logic                            watchdog_expiry_evt,
  input  wire logic                            charge_timer_expiry_evt,
  input  wire logic                            regulator_overcurrent_evt,
  input  wire logic                            button_wake_one_evt,
  input  wire logic                            button_wake_two_evt,
  input  wire logic                            button_reset_warning_evt
);
  import event_bank_pkg::*;

  // ==========================================================
  // reset release
  logic rst_meta_ff;
  logic rst_n_sync;

  // assertion is immediate, release waits two clock edges
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_ff <= 1'b0;
      rst_n_sync  <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_n_sync  <= rst_meta_ff;
    end
  end

  // ==========================================================
  // detector levels into the clock domain
  logic [NUM_SYNC-1:0] raw_lvl;
  logic [NUM_SYNC-1:0] lvl;
  logic [NUM_SYNC-1:0] prev_lvl_ff;
  logic [NUM_SYNC-1:0] nxt_prev_lvl;

  // packing order: charger 6..0, protection 13..7, converter 18..14, timers 24..19
  assign raw_lvl = {button_wake_one_evt, button_wake_two_evt, button_reset_warning_evt,
                    watchdog_expiry_evt, charge_timer_expiry_evt, regulator_overcurrent_evt,
                    adc_done_evt, comparator_one_evt, comparator_two_evt,
                    comparator_three_evt, thermistor_open_evt,
                    input_overvoltage_evt, battery_overcurrent_evt,
                    battery_undervoltage_evt, thermistor_cold_evt, thermistor_cool_evt,
                    thermistor_warm_evt, thermistor_hot_evt,
                    taper_entry_evt, charge_done_evt, input_limit_evt,
                    power_path_mgmt_evt, input_voltage_mgmt_evt,
                    thermal_regulation_evt, input_good_change_evt};

  level_sync #(.W(NUM_SYNC)) u_sync
  (
    .mclk       (mclk),
    .rst_n_sync (rst_n_sync),
    .async_in   (raw_lvl),
    .level_ff   (lvl)
  );

  // previous level for edge detection
  always_comb
  begin
    nxt_prev_lvl = lvl;
  end

  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      prev_lvl_ff <= '0;
    end
    else
    begin
      prev_lvl_ff <= nxt_prev_lvl;
    end
  end

  // ==========================================================
  // event detection
  logic [2:0] comp_dir;
  logic [2:0] comp_met;
  logic [2:0] comp_met_prev_ff;
  logic [2:0] nxt_comp_met_prev;
  logic [7:0] chg_set;
  logic [7:0] prot_set;
  logic [7:0] conv_set;
  logic [7:0] tmr_set;

  function automatic logic rise(input logic now_v, input logic was_v);
    rise = now_v & ~was_v;
  endfunction

  // condition met is above when the select is 1, below when 0
  assign comp_dir = {comparator_one_direction_sel, comparator_two_direction_sel,
                     comparator_three_direction_sel};
  assign comp_met = ~(lvl[17:15] ^ comp_dir);

  always_comb
  begin
    nxt_comp_met_prev = comp_met;
  end

  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      comp_met_prev_ff <= '0;
    end
    else
    begin
      comp_met_prev_ff <= nxt_comp_met_prev;
    end
  end

  // entry events latch on the rising level, undervoltage only on its fall; power-good on either edge
  always_comb
  begin
    chg_set = 8'h00;
    prot_set = 8'h00;
    conv_set = 8'h00;
    tmr_set = 8'h00;
    chg_set[6]  = rise(lvl[6], prev_lvl_ff[6]);
    chg_set[5]  = rise(lvl[5], prev_lvl_ff[5]);
    chg_set[4]  = rise(lvl[4], prev_lvl_ff[4]);
    chg_set[3]  = rise(lvl[3], prev_lvl_ff[3]);
    chg_set[2]  = rise(lvl[2], prev_lvl_ff[2]);
    chg_set[1]  = rise(lvl[1], prev_lvl_ff[1]);
    chg_set[PGOOD_BIT] = lvl[0] ^ prev_lvl_ff[0];
    prot_set[7] = rise(lvl[13], prev_lvl_ff[13]);
    prot_set[5] = rise(lvl[12], prev_lvl_ff[12]);
    // inverted field: 1 is latched when the battery leaves undervoltage
    prot_set[BAT_UV_BIT] = rise(prev_lvl_ff[11], lvl[11]);
    prot_set[3] = rise(lvl[10], prev_lvl_ff[10]);
    prot_set[2] = rise(lvl[9], prev_lvl_ff[9]);
    prot_set[1] = rise(lvl[8], prev_lvl_ff[8]);
    prot_set[0] = rise(lvl[7], prev_lvl_ff[7]);
    conv_set[ADC_DONE_BIT] = rise(lvl[18], prev_lvl_ff[18]);
    for (int i = 0; i < NUM_COMP; i++)
    begin
      conv_set[COMP_LO_BIT + i] = rise(comp_met[i], comp_met_prev_ff[i]);
    end
    conv_set[TS_OPEN_BIT] = rise(lvl[14], prev_lvl_ff[14]);
    tmr_set[6] = rise(lvl[21], prev_lvl_ff[21]);
    tmr_set[5] = rise(lvl[20], prev_lvl_ff[20]);
    tmr_set[4] = rise(lvl[19], prev_lvl_ff[19]);
    tmr_set[2] = rise(lvl[24], prev_lvl_ff[24]);
    tmr_set[1] = rise(lvl[23], prev_lvl_ff[23]);
    tmr_set[0] = rise(lvl[22], prev_lvl_ff[22]);
  end

  // ==========================================================
  // flag registers
  logic [7:0] chg_flags;
  logic [7:0] prot_flags;
  logic [7:0] conv_flags;
  logic [7:0] tmr_flags;
  logic       rd_chg;
  logic       rd_prot;
  logic       rd_conv;
  logic       rd_tmr;

  // address decode of reads that clear
  always_comb
  begin
    rd_chg = 1'b0;
    rd_prot = 1'b0;
    rd_conv = 1'b0;
    rd_tmr = 1'b0;
    if (reg_rd && reg_addr == CHG_FLAGS_ADDR)
      rd_chg = 1'b1;
    else if (reg_rd && reg_addr == PROT_FLAGS_ADDR)
      rd_prot = 1'b1;
    else if (reg_rd && reg_addr == CONV_FLAGS_ADDR)
      rd_conv = 1'b1;
    else if (reg_rd && reg_addr == TMR_FLAGS_ADDR)
      rd_tmr = 1'b1;
  end

  sticky_flags #(.W(8), .USED_BITS(CHG_USED_BITS)) u_chg
  (
    .mclk (mclk), .rst_n_sync (rst_n_sync), .set_bits (chg_set),
    .clear_all (rd_chg), .flags_ff (chg_flags)
  );
  sticky_flags #(.W(8), .USED_BITS(PROT_USED_BITS)) u_prot
  (
    .mclk (mclk), .rst_n_sync (rst_n_sync), .set_bits (prot_set),
    .clear_all (rd_prot), .flags_ff (prot_flags)
  );
  sticky_flags #(.W(8), .USED_BITS(CONV_USED_BITS)) u_conv
  (
    .mclk (mclk), .rst_n_sync (rst_n_sync), .set_bits (conv_set),
    .clear_all (rd_conv), .flags_ff (conv_flags)
  );
  sticky_flags #(.W(8), .USED_BITS(TMR_USED_BITS)) u_tmr
  (
    .mclk (mclk), .rst_n_sync (rst_n_sync), .set_bits (tmr_set),
    .clear_all (rd_tmr), .flags_ff (tmr_flags)
  );

  // ==========================================================
  // mask, read port and interrupt
  logic [7:0] mask_ff;
  logic [7:0] nxt_mask;
  logic [7:0] nxt_rdata;
  logic       nxt_irq;
  logic       pending;

  // writes to anything but the mask are dropped; flags are read-only
  always_comb
  begin
    nxt_mask = mask_ff;
    if (reg_wr && reg_addr == CHG_MASKS_ADDR)
      nxt_mask = reg_wdata;
  end

  // read returns the value before the clear
  always_comb
  begin
    nxt_rdata = reg_rdata_ff;
    if (reg_rd)
    begin
      if (reg_addr == CHG_FLAGS_ADDR)
        nxt_rdata = chg_flags;
      else if (reg_addr == PROT_FLAGS_ADDR)
        nxt_rdata = prot_flags;
      else if (reg_addr == CONV_FLAGS_ADDR)
        nxt_rdata = conv_flags;
      else if (reg_addr == TMR_FLAGS_ADDR)
        nxt_rdata = tmr_flags;
      else if (reg_addr == CHG_MASKS_ADDR)
        nxt_rdata = mask_ff;
      else
        nxt_rdata = UNMAPPED_DATA;
    end
  end

  // only charger flags have a mask here; the other groups always interrupt
  assign pending = (|(chg_flags & ~mask_ff)) | (|prot_flags) | (|conv_flags) | (|tmr_flags);

  // looks one cycle ahead so the request lines up with the flag bits
  always_comb
  begin
    nxt_irq = (|(((rd_chg ? 8'h00 : chg_flags) | chg_set) & CHG_USED_BITS & ~nxt_mask))
            | (|(((rd_prot ? 8'h00 : prot_flags) | prot_set) & PROT_USED_BITS))
            | (|(((rd_conv ? 8'h00 : conv_flags) | conv_set) & CONV_USED_BITS))
            | (|(((rd_tmr ? 8'h00 : tmr_flags) | tmr_set) & TMR_USED_BITS));
  end

  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      mask_ff       <= MASKS_RESET;
      reg_rdata_ff  <= FLAGS_RESET;
      reg_rvalid_ff <= 1'b0;
      irq_ff        <= 1'b0;
    end
    else
    begin
      mask_ff       <= nxt_mask;
      reg_rdata_ff  <= nxt_rdata;
      reg_rvalid_ff <= reg_rd;
      irq_ff        <= nxt_irq;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n_sync);

  a_read_clears_flags: assert property (
    (rd_chg && chg_set == 8'h00) |=> (chg_flags == 8'h00 && reg_rdata_ff == $past(chg_flags)))
    else $error("charger flags not cleared by read");
  a_taper_latch: assert property ($rose(lvl[6]) |=> chg_flags[TAPER_BIT])
    else $error("taper entry not latched");
  a_charger_latch: assert property (
    (|chg_set[5:1]) |=> ((chg_flags[5:1] & $past(chg_set[5:1])) == $past(chg_set[5:1])))
    else $error("charger event lost");
  a_pgood_either_edge: assert property ($changed(lvl[0]) |=> chg_flags[PGOOD_BIT])
    else $error("power-good change not latched");
  a_protection_latch: assert property (
    ($rose(lvl[13]) || $rose(lvl[12]) || $rose(lvl[7])) |=> (|(prot_flags & 8'ha1)))
    else $error("protection event lost");
  // entering undervoltage must leave the inverted bit at zero
  a_undervolt_inverted: assert property (
    ($rose(lvl[11]) && !prot_flags[BAT_UV_BIT] && !rd_prot) |=> !prot_flags[BAT_UV_BIT])
    else $error("undervoltage bit not inverted");
  a_undervolt_clear: assert property ($fell(lvl[11]) |=> prot_flags[BAT_UV_BIT])
    else $error("undervoltage recovery not latched");
  a_comparator_dir: assert property (
    ($rose(comp_met[2]) && !rd_conv) |=> conv_flags[6] ##1 (conv_flags[6] || $past(rd_conv)))
    else $error("comparator one not latched");
  a_converter_bits: assert property (
    (($rose(lvl[18]) |=> conv_flags[ADC_DONE_BIT]) and (conv_flags[3:1] == 3'b000)))
    else $error("converter flag wrong");
  a_timer_latch: assert property (
    (|tmr_set) |=> ((tmr_flags & $past(tmr_set)) == $past(tmr_set) && tmr_flags[3] == 1'b0))
    else $error("timer event lost");
  a_mask_write: assert property (
    (reg_wr && reg_addr == CHG_MASKS_ADDR) |=> (mask_ff == $past(reg_wdata)))
    else $error("mask write not taken");
  a_irq_follows: assert property (irq_ff == pending)
    else $error("interrupt disagrees with unmasked flags");

  c_read_meets_set: cover property (rd_chg && chg_set != 8'h00);
  c_masked_only:    cover property (chg_flags != 8'h00 && !irq_ff);
  c_irq_rise:       cover property ($rose(irq_ff));
  c_comp_below:     cover property (comp_dir[2] == 1'b0 && conv_set[6]);
endmodule

// *** design/event_bank_pkg.sv ***
// package of constants for the charger event flag and mask bank
// assumes one device clock; the register port sits behind the serial bus slave

package event_bank_pkg;
  // ==========================================================
  // register map
  localparam int         ADDR_W          = 8;
  localparam int         DATA_W          = 8;
  localparam logic [7:0] CHG_FLAGS_ADDR  = 8'h03;
  localparam logic [7:0] PROT_FLAGS_ADDR = 8'h04;
  localparam logic [7:0] CONV_FLAGS_ADDR = 8'h05;
  localparam logic [7:0] TMR_FLAGS_ADDR  = 8'h06;
  localparam logic [7:0] CHG_MASKS_ADDR  = 8'h07;
  localparam logic [7:0] FLAGS_RESET     = 8'h00;
  localparam logic [7:0] MASKS_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  // ==========================================================
  // implemented bits of each flag register; the rest read zero
  localparam logic [7:0] CHG_USED_BITS   = 8'h7f;
  localparam logic [7:0] PROT_USED_BITS  = 8'hbf;
  localparam logic [7:0] CONV_USED_BITS  = 8'hf1;
  localparam logic [7:0] TMR_USED_BITS   = 8'h77;

  // ==========================================================
  // field positions
  localparam int TAPER_BIT     = 6;
  localparam int PGOOD_BIT     = 0;
  localparam int BAT_UV_BIT    = 4;
  localparam int ADC_DONE_BIT  = 7;
  localparam int COMP_LO_BIT   = 4;
  localparam int TS_OPEN_BIT   = 0;
  localparam int NUM_COMP      = 3;
  localparam int NUM_SYNC      = 25;
endpackage

// *** design/level_sync.sv ***
// three-stage synchroniser for detector levels arriving from outside the clock
// assumes each level stays put for at least three clock periods
`timescale 1ns/10ps
module level_sync
#(
  parameter int W = 8
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n_sync,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_ff
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] nxt_level;

  // a bit only moves once the second and third stage agree
  always_comb
  begin
    nxt_level = (s2_ff & s3_ff) | (level_ff & (s2_ff | s3_ff));
  end

  // meta_ff is only read by s2_ff
  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      meta_ff  <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      level_ff <= '0;
    end
    else
    begin
      meta_ff  <= async_in;
      s2_ff    <= meta_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end
endmodule

// *** design/sticky_flags.sv ***
// one clear-on-read flag register of sticky bits
// assumes set and clear are one-cycle terms from the same clock
`timescale 1ns/10ps
module sticky_flags
#(
  parameter int         W         = 8,
  parameter logic [7:0] USED_BITS = 8'hff
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n_sync,
  input  wire logic [W-1:0] set_bits,
  input  wire logic         clear_all,
  output logic      [W-1:0] flags_ff
);
  logic [W-1:0] nxt_flags;

  // set beats clear so an event landing on the read is kept for the next one
  always_comb
  begin
    nxt_flags = ((clear_all ? '0 : flags_ff) | set_bits) & USED_BITS[W-1:0];
  end

  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      flags_ff <= '0;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end
endmodule
